/* common/adc_ctrl_pkg.sv */
// Overview of operation
// RULE_01 - Software sets conversion modes before writing the normal start bit.
// RULE_02 - Reference enable bit 7 powers reference; start waits 3 us after enabling.
// RULE_03 - Software clears reference enable before entering standby after conversion.
// RULE_04 - Idle operation bit 6: 0 halts converter in idle, 1 keeps running.
// RULE_05 - Scan width bit picks four-input groups or eight-input groups for scans.
// RULE_06 - Fixed mode selects input equal to channel code 0 to 11.
// RULE_07 - Priority done flag bit 7 reads 0 before/during, 1 after completion.
// RULE_08 - Priority busy flag bit 6 reads 1 while top-priority conversion runs.
// RULE_09 - Writing 1 to trigger starts priority conversion on chosen input; reads 0.
// RULE_10 - Reserved bit 4 of both mode registers stored and returned, otherwise ignored.
package adc_ctrl_pkg;
  localparam logic [7:0] OFS_SETUP = 8'h08;
  localparam logic [7:0] OFS_PRIO = 8'h0C;
  localparam logic [7:0] OFS_START = 8'h04;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h40;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h44;
  localparam logic [7:0] OFS_STATUS = 8'h48;
  localparam int BIT_REF_EN = 7;
  localparam int BIT_IDLE_OP = 6;
  localparam int BIT_SCAN_W = 5;
  localparam int BIT_RSVD = 4;
  localparam int BIT_PDONE = 7;
  localparam int BIT_PBUSY = 6;
  localparam int BIT_PTRIG = 5;
  localparam int BIT_START = 0;
  localparam int BIT_SCAN = 1;
  localparam logic [7:0] RESET_SETUP = 8'h00;
  localparam logic [7:0] RESET_PRIO = 8'h00;
  localparam logic [3:0] LAST_NORMAL_CH = 4'hB;
  localparam logic [3:0] LAST_PRIO_CH = 4'hC;
  localparam int CLK_MHZ = 125;
  localparam int REF_SETTLE_NS = 3000;
  localparam int REF_SETTLE_CYC = (REF_SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int IRQ_W = 4;
  localparam int IRQ_PDONE = 0;
  localparam int IRQ_NDONE = 1;
  localparam int IRQ_START_EARLY = 2;
  localparam int IRQ_BAD_CODE = 3;

  typedef struct packed {
    logic req;
    logic [3:0] ch;
  } conv_req_t;

  typedef struct packed {
    logic [3:0] first_ch;
    logic [3:0] last_ch;
  } scan_range_t;
endpackage

/* design/adc_scan_range.sv */
`timescale 1ns/10ps
module adc_scan_range (
  input wire logic i_scan,
  input wire logic i_scan_w,
  input wire logic [3:0] i_code,
  output adc_ctrl_pkg::scan_range_t o_range
);
  always_comb begin
    o_range.last_ch = i_code;
    if (!i_scan) begin
      o_range.first_ch = i_code; // RULE_06
    end else if (i_scan_w) begin
      o_range.first_ch = {i_code[3], 3'h0}; // RULE_05
    end else begin
      o_range.first_ch = {i_code[3:2], 2'h0}; // RULE_05
    end
  end
endmodule

/* design/adc_settle_timer.sv */
`timescale 1ns/10ps
module adc_settle_timer (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_enable,
  output logic o_ready
);
  logic [15:0] cnt_reg;
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt_reg <= 16'h0000;
    end else if (!i_enable) begin
      cnt_reg <= 16'h0000;
    end else if (cnt_reg != 16'(adc_ctrl_pkg::REF_SETTLE_CYC)) begin
      cnt_reg <= cnt_reg + 16'h0001; // RULE_02
    end
  end
  assign o_ready = i_enable && (cnt_reg == 16'(adc_ctrl_pkg::REF_SETTLE_CYC));
endmodule

/* design/adc_channel_and_priority_control.sv */
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/10ps
module adc_channel_and_priority_control (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_chip_idle,
  input wire logic i_core_done,
  output logic o_ref_on,
  output logic o_core_run,
  output logic o_conv_req,
  output logic o_conv_prio,
  output logic [3:0] o_conv_ch,
  output logic [3:0] o_scan_first,
  output logic [3:0] o_scan_last,
  output logic o_scan,
  output logic o_irq
);
  typedef enum logic [1:0] {ST_IDLE, ST_NORMAL, ST_PRIO} conv_state_t;

  logic [7:0] setup_reg;
  logic [7:0] prio_reg;
  logic scan_reg;
  logic normal_busy_reg;
  logic prio_done_reg;
  logic [3:0] irq_stat_reg;
  logic [3:0] irq_mask_reg;
  logic [3:0] irq_event;
  logic core_done_s1_reg;
  logic core_done_s2_reg;
  logic idle_s1_reg;
  logic idle_s2_reg;
  logic core_done_s3_reg;
  logic core_done_rise;
  logic ref_ready;
  logic wr_en;
  logic rd_en;
  logic hit;
  logic prio_trig_wr;
  logic normal_start_wr;
  logic prio_pending_reg;
  logic normal_pending_reg;
  logic run_allowed;
  logic prio_go;
  logic normal_go;
  logic setup_wr;
  logic prio_wr;
  logic start_wr;
  logic prio_code_ok;
  logic normal_code_ok;
  conv_state_t state_reg;
  adc_ctrl_pkg::conv_req_t req_reg;
  adc_ctrl_pkg::scan_range_t range;

  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] ofs);
    addr_is = (a == ofs);
  endfunction

  // A start or trigger with a prohibited code is refused and sets nothing pending
  function automatic logic code_ok(input logic [3:0] code, input logic [3:0] last);
    code_ok = (code <= last);
  endfunction

  assign wr_en = i_psel && i_penable && i_pwrite;
  // Read data captured in the setup cycle so it stands at the access edge
  assign rd_en = i_psel && !i_penable && !i_pwrite;
  assign hit = addr_is(i_paddr, adc_ctrl_pkg::OFS_SETUP) || addr_is(i_paddr, adc_ctrl_pkg::OFS_PRIO)
    || addr_is(i_paddr, adc_ctrl_pkg::OFS_START) || addr_is(i_paddr, adc_ctrl_pkg::OFS_IRQ_STATUS)
    || addr_is(i_paddr, adc_ctrl_pkg::OFS_IRQ_MASK) || addr_is(i_paddr, adc_ctrl_pkg::OFS_STATUS);
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && !hit;
  assign setup_wr = wr_en && addr_is(i_paddr, adc_ctrl_pkg::OFS_SETUP);
  assign prio_wr = wr_en && addr_is(i_paddr, adc_ctrl_pkg::OFS_PRIO);
  assign start_wr = wr_en && addr_is(i_paddr, adc_ctrl_pkg::OFS_START);
  assign prio_trig_wr = prio_wr && i_pwdata[adc_ctrl_pkg::BIT_PTRIG]; // RULE_09
  assign normal_start_wr = start_wr && i_pwdata[adc_ctrl_pkg::BIT_START];
  // Channel travels with the trigger, so the written code is the one to judge
  assign prio_code_ok = code_ok(i_pwdata[3:0], adc_ctrl_pkg::LAST_PRIO_CH); // RULE_09
  assign normal_code_ok = code_ok(setup_reg[3:0], adc_ctrl_pkg::LAST_NORMAL_CH); // RULE_06
  assign prio_go = prio_pending_reg && ref_ready && run_allowed; // RULE_02
  assign normal_go = normal_pending_reg && ref_ready && run_allowed; // RULE_02

  // Done from the analog side crosses in through two flops
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      core_done_s1_reg <= 1'b0;
      core_done_s2_reg <= 1'b0;
      core_done_s3_reg <= 1'b0;
    end else begin
      core_done_s1_reg <= i_core_done;
      core_done_s2_reg <= core_done_s1_reg;
      core_done_s3_reg <= core_done_s2_reg;
    end
  end
  // A held done level counts once, else a queued request would end at once
  assign core_done_rise = core_done_s2_reg && !core_done_s3_reg;

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      idle_s1_reg <= 1'b0;
      idle_s2_reg <= 1'b0;
    end else begin
      idle_s1_reg <= i_chip_idle;
      idle_s2_reg <= idle_s1_reg;
    end
  end

  adc_settle_timer u_settle (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_enable(setup_reg[adc_ctrl_pkg::BIT_REF_EN]),
    .o_ready(ref_ready)
  );

  adc_scan_range u_range (
    .i_scan(scan_reg),
    .i_scan_w(setup_reg[adc_ctrl_pkg::BIT_SCAN_W]),
    .i_code(setup_reg[3:0]),
    .o_range(range)
  );

  // Setup register; reserved bit kept as written
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      setup_reg <= adc_ctrl_pkg::RESET_SETUP;
    end else if (setup_wr) begin
      setup_reg <= i_pwdata[7:0]; // RULE_10
    end
  end

  // Trigger bit never stored, flags owned by hardware
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      prio_reg <= adc_ctrl_pkg::RESET_PRIO;
    end else if (prio_wr) begin
      prio_reg <= {3'h0, i_pwdata[4:0]}; // RULE_10
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      scan_reg <= 1'b0;
    end else if (start_wr) begin
      scan_reg <= i_pwdata[adc_ctrl_pkg::BIT_SCAN];
    end
  end

  // Converter halts in idle unless told to keep running
  assign run_allowed = !idle_s2_reg || setup_reg[adc_ctrl_pkg::BIT_IDLE_OP]; // RULE_04

  // Requests wait here until the reference has settled
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      prio_pending_reg <= 1'b0;
    end else if (prio_trig_wr && prio_code_ok) begin
      prio_pending_reg <= 1'b1; // RULE_09
    end else if (state_reg == ST_PRIO) begin
      prio_pending_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      normal_pending_reg <= 1'b0;
    end else if (normal_start_wr && normal_code_ok) begin
      normal_pending_reg <= 1'b1;
    end else if (state_reg == ST_NORMAL) begin
      normal_pending_reg <= 1'b0;
    end
  end

  // Priority request preempts a pending normal one
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_reg <= ST_IDLE;
      req_reg <= '0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (prio_go) begin
            state_reg <= ST_PRIO;
            req_reg <= '{req: 1'b1, ch: prio_reg[3:0]}; // RULE_09
          end else if (normal_go) begin
            state_reg <= ST_NORMAL;
            req_reg <= '{req: 1'b1, ch: range.first_ch}; // RULE_06
          end
        end
        ST_NORMAL, ST_PRIO: begin
          req_reg.req <= 1'b0;
          if (core_done_rise) begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Done flag drops when the trigger bit is written, before the priority run begins; a priority completion in that cycle sets it instead
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      prio_done_reg <= 1'b0;
    end else if (state_reg == ST_PRIO && core_done_rise) begin
      prio_done_reg <= 1'b1; // RULE_07
    end else if (prio_trig_wr) begin
      prio_done_reg <= 1'b0; // RULE_07
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      normal_busy_reg <= 1'b0;
    end else begin
      normal_busy_reg <= (state_reg == ST_NORMAL);
    end
  end

  always_comb begin
    irq_event = '0;
    irq_event[adc_ctrl_pkg::IRQ_PDONE] = (state_reg == ST_PRIO) && core_done_rise;
    irq_event[adc_ctrl_pkg::IRQ_NDONE] = (state_reg == ST_NORMAL) && core_done_rise;
    irq_event[adc_ctrl_pkg::IRQ_START_EARLY] = (normal_start_wr || prio_trig_wr) && !ref_ready;
    irq_event[adc_ctrl_pkg::IRQ_BAD_CODE] = (normal_start_wr && !normal_code_ok)
      || (prio_trig_wr && !prio_code_ok);
  end

  // Set beats a simultaneous write-one clear
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      irq_stat_reg <= '0;
    end else if (wr_en && addr_is(i_paddr, adc_ctrl_pkg::OFS_IRQ_STATUS)) begin
      irq_stat_reg <= (irq_stat_reg & ~i_pwdata[3:0]) | irq_event;
    end else begin
      irq_stat_reg <= irq_stat_reg | irq_event;
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      irq_mask_reg <= '0;
    end else if (wr_en && addr_is(i_paddr, adc_ctrl_pkg::OFS_IRQ_MASK)) begin
      irq_mask_reg <= i_pwdata[3:0];
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_irq <= 1'b0;
    end else begin
      // A set mask bit keeps its status bit off the line
      o_irq <= |(irq_stat_reg & ~irq_mask_reg);
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_prdata <= '0;
    end else if (rd_en) begin
      case (i_paddr)
        adc_ctrl_pkg::OFS_SETUP: o_prdata <= {24'h000000, setup_reg};
        adc_ctrl_pkg::OFS_PRIO: begin
          o_prdata <= {24'h000000, prio_done_reg, state_reg == ST_PRIO, 1'b0, prio_reg[4:0]}; // RULE_08
        end
        adc_ctrl_pkg::OFS_START: o_prdata <= {30'h00000000, scan_reg, 1'b0};
        adc_ctrl_pkg::OFS_IRQ_STATUS: o_prdata <= {28'h0000000, irq_stat_reg};
        adc_ctrl_pkg::OFS_IRQ_MASK: o_prdata <= {28'h0000000, irq_mask_reg};
        adc_ctrl_pkg::OFS_STATUS: o_prdata <= {29'h00000000, ref_ready, prio_pending_reg, normal_busy_reg};
        default: o_prdata <= '0;
      endcase
    end
  end

  // Reference follows its bit one cycle later; the settle wait gates starts instead
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_ref_on <= 1'b0;
    end else begin
      o_ref_on <= setup_reg[adc_ctrl_pkg::BIT_REF_EN]; // RULE_02
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_core_run <= 1'b0;
    end else begin
      o_core_run <= run_allowed; // RULE_04
    end
  end

  // Request pulse and channel launch on the same edge; range outputs reload from setup and scan bits every cycle
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_conv_req <= 1'b0;
    end else begin
      o_conv_req <= req_reg.req;
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_conv_prio <= 1'b0;
    end else begin
      o_conv_prio <= (state_reg == ST_PRIO); // RULE_08
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_conv_ch <= 4'h0;
    end else begin
      o_conv_ch <= req_reg.ch;
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_scan_first <= 4'h0;
    end else begin
      o_scan_first <= range.first_ch; // RULE_05
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_scan_last <= 4'h0;
    end else begin
      o_scan_last <= range.last_ch; // RULE_05
    end
  end

  // Scan flag dropped while a priority run owns the core
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_scan <= 1'b0;
    end else begin
      o_scan <= scan_reg && (state_reg != ST_PRIO);
    end
  end
endmodule

/* dv/adc_ctrl_checker.sv */
`timescale 1ns/10ps
module adc_ctrl_checker (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic i_core_done,
  input wire logic [31:0] o_prdata,
  input wire logic o_pslverr,
  input wire logic o_ref_on,
  input wire logic o_core_run,
  input wire logic o_conv_req,
  input wire logic o_conv_prio,
  input wire logic [3:0] o_conv_ch,
  input wire logic [3:0] o_scan_first,
  input wire logic [3:0] o_scan_last,
  input wire logic o_scan
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  logic rd_prio;
  assign rd_prio = i_psel && i_penable && !i_pwrite && i_paddr == adc_ctrl_pkg::OFS_PRIO;
  property p_ref; o_conv_req |-> o_ref_on; endproperty
  a_ref: assert property (p_ref) else $error("start with reference off");
  property p_run; o_conv_req |-> o_core_run; endproperty
  a_run: assert property (p_run) else $error("start while halted");
  property p_chlim; o_conv_req |-> o_conv_ch <= adc_ctrl_pkg::LAST_PRIO_CH; endproperty
  a_chlim: assert property (p_chlim) else $error("channel out of range");
  property p_nch; o_conv_req && !o_conv_prio |-> o_conv_ch <= adc_ctrl_pkg::LAST_NORMAL_CH; endproperty
  a_nch: assert property (p_nch) else $error("normal channel out of range");
  property p_scan;
    o_conv_req && o_scan |-> o_conv_ch == o_scan_first && o_scan_first[1:0] == 2'h0 && o_scan_first <= o_scan_last;
  endproperty
  a_scan: assert property (p_scan) else $error("bad scan range");
  property p_trig; rd_prio |-> !o_prdata[adc_ctrl_pkg::BIT_PTRIG]; endproperty
  a_trig: assert property (p_trig) else $error("trigger bit read as one");
  property p_flags; rd_prio |-> !(o_prdata[7] && o_prdata[6]); endproperty
  a_flags: assert property (p_flags) else $error("busy and done together");
  property p_end; $rose(i_core_done) && o_conv_prio |-> ##[1:8] !o_conv_prio; endproperty
  a_end: assert property (p_end) else $error("priority never ends");
  c_prio: cover property (o_conv_req && o_conv_prio);
  c_scan: cover property (o_conv_req && o_scan);
  c_err: cover property (i_psel && i_penable && o_pslverr);
endmodule
bind adc_channel_and_priority_control adc_ctrl_checker i_chk (.i_mclk, .i_sys_rst, .i_psel, .i_penable, .i_pwrite,
  .i_paddr, .i_core_done, .o_prdata, .o_pslverr, .o_ref_on, .o_core_run, .o_conv_req, .o_conv_prio, .o_conv_ch,
  .o_scan_first, .o_scan_last, .o_scan);

/* dv/adc_core_model.sv */
`timescale 1ns/10ps
module adc_core_model #(
  parameter int DLY = 12
) (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_conv_req,
  output logic o_done
);
  int cnt;
  // Done held four cycles so the two-stage sync cannot miss it
  assign o_done = cnt >= 1 && cnt <= 4;
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst)
      cnt <= 0;
    else if (i_conv_req)
      cnt <= DLY + 4;
    else if (cnt > 0)
      cnt <= cnt - 1;
  end
endmodule

/* dv/tb_adc_channel_and_priority_control.sv */
`timescale 1ns/10ps
module tb_adc_channel_and_priority_control;
  typedef struct packed {
    logic [7:0] set;
    logic [7:0] sa;
    logic [7:0] sd;
    logic [13:0] exp;
    logic [13:0] msk;
  } row_t;
  logic i_mclk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic i_chip_idle = 1'b0;
  logic [7:0] i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0;
  logic [31:0] o_prdata, rd;
  logic err;
  logic o_pready, o_pslverr, i_core_done, o_ref_on, o_core_run, o_conv_req, o_conv_prio, o_scan, o_irq;
  logic [3:0] o_conv_ch, o_scan_first, o_scan_last;
  int num_errors = 0;
  int samples_checked = 0;
  int nreq = 0;
  int n;
  row_t rows [8] = '{'{8'h85, 8'h04, 8'h01, 14'h0500, 14'h3F00}, '{8'h8B, 8'h04, 8'h01, 14'h0B00, 14'h3F00},
    '{8'h86, 8'h04, 8'h03, 14'h1446, 14'h3FFF}, '{8'hA6, 8'h04, 8'h03, 14'h1006, 14'h3FFF},
    '{8'hAA, 8'h04, 8'h03, 14'h188A, 14'h3FFF}, '{8'h8B, 8'h04, 8'h03, 14'h188B, 14'h3FFF},
    '{8'h80, 8'h0C, 8'h2C, 14'h2C00, 14'h2F00}, '{8'h80, 8'h0C, 8'h20, 14'h2000, 14'h2F00}};
  always #4 i_mclk = ~i_mclk;
  adc_channel_and_priority_control i_dut (.i_mclk, .i_sys_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr,
    .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_chip_idle, .i_core_done, .o_ref_on, .o_core_run,
    .o_conv_req, .o_conv_prio, .o_conv_ch, .o_scan_first, .o_scan_last, .o_scan, .o_irq);
  adc_core_model i_core (.i_mclk, .i_sys_rst, .i_conv_req(o_conv_req), .o_done(i_core_done));
  always @(posedge i_mclk) if (o_conv_req === 1'b1) nreq++;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks=%0d errors=%0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Request held until pready is seen high; data and error taken at that edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_mclk);
    i_penable <= 1'b1;
    @(posedge i_mclk);
    while (o_pready !== 1'b1) @(posedge i_mclk);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_mclk);
  endtask
  initial begin
    repeat (20000) @(posedge i_mclk);
    num_errors++;
    stop_test();
  end
  initial begin
    repeat (8) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    @(posedge i_mclk);
    foreach (rows[i]) begin
      apb(1'b1, 8'h08, {24'h0, rows[i].set});
      apb(1'b1, rows[i].sa, {24'h0, rows[i].sd});
      n = 0;
      while (o_conv_req !== 1'b1 && n < 1000) begin
        @(posedge i_mclk);
        n++;
      end
      chk(32'(o_conv_req), 32'h1);
      chk(32'({o_conv_prio, o_scan, o_conv_ch, o_scan_first, o_scan_last} & rows[i].msk), 32'(rows[i].exp));
      if (i == 0) chk(32'(n >= adc_ctrl_pkg::REF_SETTLE_CYC - 4), 32'h1);
      repeat (40) @(posedge i_mclk);
    end
    $display("conversion rows done");
    chk(32'(o_ref_on), 32'h1);
    apb(1'b1, 8'h0C, 32'h2C);
    apb(1'b0, 8'h0C, 32'h0);
    chk(rd, 32'h4C);
    repeat (40) @(posedge i_mclk);
    apb(1'b0, 8'h0C, 32'h0);
    chk(rd, 32'h8C);
    n = nreq;
    apb(1'b1, 8'h0C, 32'h2D);
    apb(1'b1, 8'h08, 32'h8D);
    apb(1'b1, 8'h04, 32'h01);
    repeat (30) @(posedge i_mclk);
    chk(32'(nreq), 32'(n));
    $display("priority and refusal done");
    apb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0F);
    chk(o_irq, 1'b1);
    apb(1'b1, 8'h44, 32'h0F);
    repeat (2) @(posedge i_mclk);
    chk(o_irq, 1'b0);
    apb(1'b1, 8'h44, 32'h00);
    apb(1'b1, 8'h40, 32'h0F);
    repeat (2) @(posedge i_mclk);
    chk(o_irq, 1'b0);
    $display("interrupt done");
    apb(1'b1, 8'h08, 32'h1A);
    apb(1'b1, 8'h10, 32'hFF);
    apb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    chk(32'(err), 32'h1);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h1A);
    chk(32'(err), 32'h0);
    i_chip_idle <= 1'b1;
    repeat (6) @(posedge i_mclk);
    chk(o_core_run, 1'b0);
    chk(32'(o_ref_on), 32'h0);
    apb(1'b1, 8'h08, 32'h40);
    repeat (4) @(posedge i_mclk);
    chk(o_core_run, 1'b1);
    i_chip_idle <= 1'b0;
    $display("registers and idle done");
    i_sys_rst <= 1'b1;
    repeat (2) @(posedge i_mclk);
    chk(32'({o_ref_on, o_core_run, o_conv_req, o_conv_prio, o_irq}), 32'h0);
    i_sys_rst <= 1'b0;
    @(posedge i_mclk);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h0C, 32'h0);
    chk(rd, 32'h0);
    $display("reset done");
    stop_test();
  end
endmodule
